// File: hdl/cssp_port.sv
`timescale 1ns/100ps
module cssp_port (
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic [5:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [31:0] WRITEDATA,
  input wire logic [3:0] BYTEENABLE,
  output logic [31:0] READDATA,
  output logic WAITREQUEST,
  input wire logic SCK_IN,
  output logic SCK_OUT,
  output logic SCK_OE,
  input wire logic SI,
  output logic SO,
  output logic SO_OE
);
  cssp_pkg::cssp_regs_type s;
  cssp_pkg::cssp_regs_type next_s;
  logic tick;
  logic [3:0] idx;
  logic wr;
  logic mode_wr;
  logic start_wr;
  logic internal;
  logic ena;
  logic cont;
  logic gen;
  logic fall;
  logic rise;

  cssp_prescaler u_prescaler (
    .mclk(MCLK),
    .rstn(RSTN),
    .src(s.serial_mode_control[2:0]),
    .tick(tick)
  );

  // ------------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------------
  assign idx = ADDRESS[5:2];
  assign wr = WRITE && !s.wait_req && BYTEENABLE[0];
  assign mode_wr = wr && (idx == cssp_pkg::IDX_MODE);
  assign start_wr = wr && (idx == cssp_pkg::IDX_CTRL) &&
                    WRITEDATA[cssp_pkg::CTRL_START];
  assign internal = s.serial_mode_control[2:0] != cssp_pkg::SRC_EXT;
  assign ena = s.serial_mode_control[cssp_pkg::SMR_PIN_BIT];
  assign cont = s.pin_mode_register_a == cssp_pkg::PM_CONT;
  assign gen = ena && internal && (s.st != cssp_pkg::ST_SWAIT);

  // Clock edges are ignored in start wait, whatever their source.
  always_comb begin
    if (internal) begin
      fall = gen && tick && s.sck;
      rise = gen && tick && !s.sck;
    end else begin
      fall = ena && (s.st != cssp_pkg::ST_SWAIT) && s.sck_prev && !SCK_IN;
      rise = ena && (s.st != cssp_pkg::ST_SWAIT) && !s.sck_prev && SCK_IN;
    end
  end

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.sck_prev = SCK_IN;

    // Each access is held off one cycle, so read data are ready.
    next_s.wait_req = !((READ || WRITE) && s.wait_req);
    next_s.rdata = '0;
    case (idx)
      cssp_pkg::IDX_CTRL: begin
        next_s.rdata[2:0] = s.st;
        next_s.rdata[cssp_pkg::CTRL_CNT_LSB +: 3] = s.cnt;
        next_s.rdata[cssp_pkg::CTRL_PEND] = s.pend != 2'h0;
      end
      cssp_pkg::IDX_FLAG: next_s.rdata[cssp_pkg::FLAG_BIT] = s.flag;
      cssp_pkg::IDX_PIN_MODE_REGISTER_A: next_s.rdata[1:0] = s.pin_mode_register_a;
      cssp_pkg::IDX_PORT: begin
        next_s.rdata[cssp_pkg::PORT_DAT] = s.port_dat;
        next_s.rdata[cssp_pkg::PORT_DIR] = s.port_dir;
        next_s.rdata[cssp_pkg::PORT_PIN] = SCK_IN;
      end
      cssp_pkg::IDX_DLO: next_s.rdata[3:0] = s.sd[3:0];
      cssp_pkg::IDX_DHI: next_s.rdata[3:0] = s.sd[7:4];
      default: next_s.rdata = '0;
    endcase

    // A clear by software comes first so that a set in the same
    // cycle wins.
    if (wr && (idx == cssp_pkg::IDX_FLAG) &&
        WRITEDATA[cssp_pkg::FLAG_BIT]) begin
      next_s.flag = 1'b0;
    end

    // New mode contents reach the logic two cycles after the write.
    if (s.pend != 2'h0) begin
      next_s.pend = s.pend - 2'h1;
      if (s.pend == 2'h1) begin
        next_s.serial_mode_control = s.smr_new;
      end
    end

    if (gen && tick) begin
      next_s.sck = !s.sck;
    end

    if (fall && !cont) begin
      if (s.st == cssp_pkg::ST_CWAIT) begin
        next_s.st = cssp_pkg::ST_XFER;
      end
      if (s.pin_mode_register_a[cssp_pkg::PM_TX_BIT]) begin
        next_s.so = s.sd[0];
      end
    end

    if (rise && !cont && (s.st == cssp_pkg::ST_XFER)) begin
      next_s.sd = {s.pin_mode_register_a[cssp_pkg::PM_RX_BIT] ? SI : 1'b0,
                   s.sd[7:1]};
      next_s.cnt = s.cnt + 3'h1;
      if (s.cnt == cssp_pkg::CNT_LAST) begin
        next_s.flag = 1'b1;
        if (internal) begin
          next_s.st = cssp_pkg::ST_SWAIT;
        end else begin
          next_s.st = cssp_pkg::ST_CWAIT;
        end
      end
    end

    // Software writes override the serial side in the same cycle.
    if (wr) begin
      case (idx)
        cssp_pkg::IDX_MODE: begin
          next_s.smr_new = WRITEDATA[3:0];
          next_s.pend = cssp_pkg::MODE_DELAY;
          next_s.st = cssp_pkg::ST_SWAIT;
          next_s.cnt = 3'h0;
          next_s.sck = 1'b1;
          if (s.st == cssp_pkg::ST_XFER) begin
            next_s.flag = 1'b1;
          end
        end
        cssp_pkg::IDX_CTRL: begin
          if (WRITEDATA[cssp_pkg::CTRL_START]) begin
            next_s.cnt = 3'h0;
            next_s.st = cssp_pkg::ST_CWAIT;
            next_s.sck = 1'b1;
            if (s.st == cssp_pkg::ST_XFER) begin
              next_s.flag = 1'b1;
            end
          end
        end
        cssp_pkg::IDX_PIN_MODE_REGISTER_A: begin
          next_s.pin_mode_register_a = WRITEDATA[1:0];
          if (WRITEDATA[1:0] != s.pin_mode_register_a) begin
            next_s.st = cssp_pkg::ST_SWAIT;
            next_s.cnt = 3'h0;
            next_s.sck = 1'b1;
          end
        end
        cssp_pkg::IDX_PORT: begin
          next_s.port_dat = WRITEDATA[cssp_pkg::PORT_DAT];
          next_s.port_dir = WRITEDATA[cssp_pkg::PORT_DIR];
        end
        cssp_pkg::IDX_DLO: next_s.sd[3:0] = WRITEDATA[3:0];
        cssp_pkg::IDX_DHI: next_s.sd[7:4] = WRITEDATA[3:0];
        default: begin
        end
      endcase
    end

    // The shared pin is either the port bit or the serial clock.
    if (next_s.serial_mode_control[cssp_pkg::SMR_PIN_BIT]) begin
      next_s.sck_out = next_s.sck;
      next_s.sck_oe = next_s.serial_mode_control[2:0] != cssp_pkg::SRC_EXT;
    end else begin
      next_s.sck_out = next_s.port_dat;
      next_s.sck_oe = next_s.port_dir;
    end
    next_s.so_oe = next_s.serial_mode_control[cssp_pkg::SMR_PIN_BIT] &&
                   next_s.pin_mode_register_a[cssp_pkg::PM_TX_BIT];
  end

  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      s <= '0;
      s.wait_req <= 1'b1;
      s.serial_mode_control <= cssp_pkg::SMR_RESET;
      s.smr_new <= cssp_pkg::SMR_RESET;
      s.pin_mode_register_a <= cssp_pkg::PIN_MODE_REGISTER_A_RESET;
      s.sd <= cssp_pkg::SD_RESET;
      s.st <= cssp_pkg::ST_SWAIT;
      s.sck <= 1'b1;
      s.sck_prev <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign READDATA = s.rdata;
  assign WAITREQUEST = s.wait_req;
  assign SCK_OUT = s.sck_out;
  assign SCK_OE = s.sck_oe;
  assign SO = s.so;
  assign SO_OE = s.so_oe;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  sequence s_mode_wr;
    mode_wr;
  endsequence

  sequence s_wrap;
    rise && !cont && (s.st == cssp_pkg::ST_XFER) &&
    (s.cnt == cssp_pkg::CNT_LAST) && !wr;
  endsequence

  property p_start_clr;
    @(posedge MCLK) disable iff (!RSTN)
    start_wr |=> (s.cnt == 3'h0) && (s.st == cssp_pkg::ST_CWAIT);
  endproperty
  a_start_clr: assert property (p_start_clr)
    else $error("start did not clear the counter");

  property p_count;
    @(posedge MCLK) disable iff (!RSTN)
    rise && !cont && !wr && (s.st == cssp_pkg::ST_XFER) |=>
      s.cnt == 3'($past(s.cnt) + 3'h1);
  endproperty
  a_count: assert property (p_count)
    else $error("counter did not step on a rising edge");

  property p_wrap;
    @(posedge MCLK) disable iff (!RSTN)
    s_wrap |=> s.flag && (s.cnt == 3'h0) &&
      (s.st == ($past(internal) ? cssp_pkg::ST_SWAIT
                                : cssp_pkg::ST_CWAIT));
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("wrap did not raise the flag or leave transfer");

  property p_mode_abort;
    @(posedge MCLK) disable iff (!RSTN)
    s_mode_wr |=> (s.st == cssp_pkg::ST_SWAIT) && (s.cnt == 3'h0) &&
      (s.flag || ($past(s.st) != cssp_pkg::ST_XFER));
  endproperty
  a_mode_abort: assert property (p_mode_abort)
    else $error("mode write did not reset the interface");

  // The new contents take over at the second edge after the commit.
  sequence s_mode_kept;
    s.serial_mode_control == $past(s.serial_mode_control);
  endsequence

  property p_mode_delay;
    @(posedge MCLK) disable iff (!RSTN)
    s_mode_wr |=> s_mode_kept ##1 s_mode_kept ##1
      (s.serial_mode_control == $past(WRITEDATA[3:0], 3));
  endproperty
  a_mode_delay: assert property (p_mode_delay)
    else $error("mode contents not applied in the second cycle");

  property p_reset_mode;
    @(posedge MCLK) disable iff (!RSTN)
    $rose(RSTN) |-> (s.serial_mode_control == cssp_pkg::SMR_RESET) && !SCK_OE;
  endproperty
  a_reset_mode: assert property (p_reset_mode)
    else $error("mode register not zero after reset");

  property p_lsb_out;
    @(posedge MCLK) disable iff (!RSTN)
    fall && !cont && s.pin_mode_register_a[cssp_pkg::PM_TX_BIT] |=>
      SO == $past(s.sd[0]);
  endproperty
  a_lsb_out: assert property (p_lsb_out)
    else $error("output bit is not the low data bit");

  property p_sample_in;
    @(posedge MCLK) disable iff (!RSTN)
    rise && !cont && !wr && (s.st == cssp_pkg::ST_XFER) &&
      s.pin_mode_register_a[cssp_pkg::PM_RX_BIT] |=> s.sd[7] == $past(SI);
  endproperty
  a_sample_in: assert property (p_sample_in)
    else $error("input pin not sampled on a rising edge");

  property p_swait_hold;
    @(posedge MCLK) disable iff (!RSTN)
    (s.st == cssp_pkg::ST_SWAIT) && !start_wr |=>
      (s.st == cssp_pkg::ST_SWAIT) && $stable(s.cnt);
  endproperty
  a_swait_hold: assert property (p_swait_hold)
    else $error("interface left start wait without a start");

  property p_flag_hold;
    @(posedge MCLK) disable iff (!RSTN)
    s.flag && !(wr && (idx == cssp_pkg::IDX_FLAG)) |=> s.flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("flag dropped without a software clear");

  property p_pin_port;
    @(posedge MCLK) disable iff (!RSTN)
    !s.serial_mode_control[cssp_pkg::SMR_PIN_BIT] && (s.pend == 2'h0) && !wr |=>
      (SCK_OE == $past(s.port_dir)) && (SCK_OUT == $past(s.port_dat));
  endproperty
  a_pin_port: assert property (p_pin_port)
    else $error("shared pin does not follow the port bit");

  property p_cwait_fall;
    @(posedge MCLK) disable iff (!RSTN)
    fall && !cont && !wr && (s.st == cssp_pkg::ST_CWAIT) |=>
      s.st == cssp_pkg::ST_XFER;
  endproperty
  a_cwait_fall: assert property (p_cwait_fall)
    else $error("first falling clock did not enter transfer");

  property p_cont_hold;
    @(posedge MCLK) disable iff (!RSTN)
    cont && !wr && (s.st == cssp_pkg::ST_CWAIT) |=>
      (s.st == cssp_pkg::ST_CWAIT) && $stable(s.cnt) && $stable(s.sd);
  endproperty
  a_cont_hold: assert property (p_cont_hold)
    else $error("continuous clock mode left clock wait");

  // A pending mode update may move the pin, so only a settled mode counts.
  property p_swait_quiet;
    @(posedge MCLK) disable iff (!RSTN)
    ena && internal && (s.st == cssp_pkg::ST_SWAIT) && (s.pend == 2'h0) &&
      !wr |=> $stable(SCK_OUT);
  endproperty
  a_swait_quiet: assert property (p_swait_quiet)
    else $error("internal clock ran outside a transfer");

  property p_start_abort;
    @(posedge MCLK) disable iff (!RSTN)
    start_wr && (s.st == cssp_pkg::ST_XFER) |=> s.flag;
  endproperty
  a_start_abort: assert property (p_start_abort)
    else $error("start during transfer did not raise the flag");

  property p_nibble_wr;
    @(posedge MCLK) disable iff (!RSTN)
    wr && (idx == cssp_pkg::IDX_DLO) |=>
      s.sd[3:0] == $past(WRITEDATA[3:0]);
  endproperty
  a_nibble_wr: assert property (p_nibble_wr)
    else $error("low data nibble write did not land");
endmodule // cssp_port

// File: hdl/cssp_pkg.sv
package cssp_pkg;
  // Functional notes
  // - Start instruction begins operation, clears counter.
  // - Counter starts on fall, counts on rise.
  // - Flag sets on wrap or on abort.
  // - Pin mode bits choose the operating mode.
  // - Mode changes enter start wait, clocks ignored.
  // - First fall enters transfer, counts and shifts.
  // - Continuous mode stays in clock wait.
  // - External clock: wrap returns to clock wait.
  // - Internal clock: wrap returns to start wait.
  // - Internal clock emits exactly eight pulses, except in continuous mode, where it runs on.
  // - Extra clocks restart transfer from clock wait.
  // - Mode write blocks clock, clears, aborts.
  // - Mode contents apply two cycles after write.
  // - Mode register resets to zero.
  // - Output shifts least bit first on fall.
  // - Input sampled into data on rise.
  // - Mode bit three selects shared pin function.
  // - Mode bits two to zero select clock.
  // - Data register has two nibble halves.

  // ------------------------------------------------------------------
  // Register map: word index, byte address is four times the index
  // ------------------------------------------------------------------
  localparam logic [3:0] IDX_CTRL = 4'h0;
  localparam logic [3:0] IDX_FLAG = 4'h1;
  localparam logic [3:0] IDX_PIN_MODE_REGISTER_A = 4'h2;
  localparam logic [3:0] IDX_PORT = 4'h3;
  localparam logic [3:0] IDX_MODE = 4'h5;
  localparam logic [3:0] IDX_DLO = 4'h6;
  localparam logic [3:0] IDX_DHI = 4'h7;

  // ------------------------------------------------------------------
  // Field positions and values
  // ------------------------------------------------------------------
  localparam int CTRL_START = 0;
  localparam int CTRL_CNT_LSB = 4;
  localparam int CTRL_PEND = 8;
  localparam int FLAG_BIT = 0;
  localparam int PORT_DAT = 0;
  localparam int PORT_DIR = 1;
  localparam int PORT_PIN = 2;
  localparam int SMR_PIN_BIT = 3;
  localparam int PM_TX_BIT = 0;
  localparam int PM_RX_BIT = 1;
  localparam logic [1:0] PM_CONT = 2'h0;
  localparam logic [2:0] SRC_LAST_PS = 3'h5;
  localparam logic [2:0] SRC_SYSCLK = 3'h6;
  localparam logic [2:0] SRC_EXT = 3'h7;
  localparam logic [3:0] SMR_RESET = 4'h0;
  localparam logic [7:0] SD_RESET = 8'h00;
  localparam logic [1:0] PIN_MODE_REGISTER_A_RESET = 2'h0;
  localparam logic [2:0] CNT_LAST = 3'h7;
  localparam logic [1:0] MODE_DELAY = 2'h2;

  // Half periods of the prescaled clock, in MCLK cycles, minus one.
  localparam logic [10:0] HALF_MASK [6] = '{
    11'h7ff, 11'h1ff, 11'h07f, 11'h01f, 11'h007, 11'h001
  };

  typedef enum logic [2:0] {
    ST_SWAIT = 3'h1,
    ST_CWAIT = 3'h2,
    ST_XFER = 3'h4
  } cssp_state_code_type;

  typedef struct packed {
    logic wait_req;
    logic [31:0] rdata;
    logic [3:0] serial_mode_control;
    logic [3:0] smr_new;
    logic [1:0] pend;
    logic [1:0] pin_mode_register_a;
    logic port_dat;
    logic port_dir;
    logic [7:0] sd;
    logic [2:0] cnt;
    cssp_state_code_type st;
    logic flag;
    logic sck;
    logic sck_prev;
    logic so;
    logic so_oe;
    logic sck_out;
    logic sck_oe;
  } cssp_regs_type;

  typedef struct packed {
    logic [10:0] free;
    logic tick;
  } cssp_ps_type;
endpackage

// File: hdl/cssp_prescaler.sv
`timescale 1ns/100ps
module cssp_prescaler (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [2:0] src,
  output logic tick
);
  cssp_pkg::cssp_ps_type s;
  cssp_pkg::cssp_ps_type next_s;
  logic [10:0] mask;

  // ------------------------------------------------------------------
  // Free running prescaler
  // ------------------------------------------------------------------
  // The prescaler never stops, so the first half period after a start
  // may be short; this matches a shared free running divider.
  always_comb begin
    next_s = s;
    mask = '1;
    if (src <= cssp_pkg::SRC_LAST_PS) begin
      mask = cssp_pkg::HALF_MASK[src];
    end
    next_s.free = s.free + 11'h001;
    next_s.tick = (src == cssp_pkg::SRC_SYSCLK) ||
                  ((src <= cssp_pkg::SRC_LAST_PS) &&
                   ((s.free & mask) == mask));
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;
endmodule // cssp_prescaler

// File: sim/cssp_peer.sv
`timescale 1ns/100ps
module cssp_peer (
  input wire logic mclk,
  input wire logic sck,
  input wire logic so,
  output logic si,
  output logic ck,
  output logic ck_oe
);
  logic sck_q = 1'b1;
  logic [7:0] tx = 8'h00;
  logic [7:0] rx = 8'h00;
  logic [3:0] idx = 4'h0;
  initial begin
    si = 1'b0;
    ck = 1'b1;
    ck_oe = 1'b0;
  end
  // New bits go out on the falling clock so they settle half a period
  // before the device samples; past bit eight the line toggles.
  always @(posedge mclk) begin
    sck_q <= sck;
    if (sck_q && !sck) si <= idx[3] ? !si : tx[idx[2:0]];
    if (!sck_q && sck) begin
      rx <= {so, rx[7:1]};
      idx <= idx + 4'h1;
    end
  end
  task automatic load(input logic [7:0] b);
    tx <= b;
    idx <= 4'h0;
    si <= b[0];
  endtask
  // The pin is driven only while clocking; a pull-up holds it high.
  task automatic pulses(input int n, input int h);
    ck_oe <= 1'b1;
    repeat (n) begin
      ck <= 1'b0;
      repeat (h) @(posedge mclk);
      ck <= 1'b1;
      repeat (h) @(posedge mclk);
    end
    ck_oe <= 1'b0;
  endtask
endmodule // cssp_peer

// File: sim/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic MCLK, RSTN, READ, WRITE, WAITREQUEST, SCK_OUT, SCK_OE, SO, SO_OE;
  logic si, ck, ck_oe, pin_q;
  logic [5:0] ADDRESS;
  logic [3:0] BYTEENABLE, lo;
  logic [31:0] WRITEDATA, READDATA, d;
  int fail_count = 0, n_checks = 0, falls = 0, per = 0, last = 0, cyc = 0;
  wire logic sck_pin = (SCK_OE === 1'b1) ? SCK_OUT : (ck_oe ? ck : 1'b1);
  cssp_port cssp_port_inst (.MCLK(MCLK), .RSTN(RSTN), .ADDRESS(ADDRESS),
    .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA),
    .BYTEENABLE(BYTEENABLE), .READDATA(READDATA),
    .WAITREQUEST(WAITREQUEST), .SCK_IN(sck_pin), .SCK_OUT(SCK_OUT),
    .SCK_OE(SCK_OE), .SI(si), .SO(SO), .SO_OE(SO_OE));
  cssp_peer cssp_peer_inst (.mclk(MCLK), .sck(sck_pin), .so(SO), .si(si),
    .ck(ck), .ck_oe(ck_oe));
  initial begin
    MCLK = 1'b0;
    forever #12.5 MCLK = ~MCLK;
  end
  always @(posedge MCLK) begin
    cyc++;
    pin_q <= sck_pin;
    if (pin_q === 1'b1 && sck_pin === 1'b0) begin
      falls++;
      per = cyc - last;
      last = cyc;
    end
  end
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      $display("BAD %s exp %h seen %h", nm, e, s);
      fail_count++;
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic stop;
    fail_count++;
    print_verdict();
  endtask
  // One wait cycle is expected, but any latency is accepted up to the bound.
  task automatic bus(input logic w, input logic [3:0] i, v);
    int n = 0;
    ADDRESS <= {i, 2'h0};
    WRITE <= w;
    READ <= !w;
    WRITEDATA <= {28'h0000000, v};
    BYTEENABLE <= 4'h1;
    do @(posedge MCLK); while (WAITREQUEST !== 1'b0 && ++n < 64);
    d = READDATA;
    WRITE <= 1'b0;
    READ <= 1'b0;
    @(posedge MCLK);
    if (n >= 64) stop();
  endtask
  task automatic wr(input logic [3:0] i, v);
    bus(1'b1, i, v);
  endtask
  task automatic rc(input string nm, input logic [3:0] i, input logic [8:0] e);
    bus(1'b0, i, 4'h0);
    chk(nm, 32'(d[8:0]), 32'(e));
  endtask
  task automatic rd8;
    bus(1'b0, 4'h6, 4'h0);
    lo = d[3:0];
    bus(1'b0, 4'h7, 4'h0);
  endtask
  task automatic setup(input logic [1:0] pm, input logic [3:0] md);
    wr(4'h2, {2'h0, pm});
    wr(4'h5, md);
    wr(4'h1, 4'h1);
    rc("setup", 4'h0, 9'h001);
    chk("sck oe", 32'(SCK_OE), 32'(md[2:0] != 3'h7));
  endtask
  task automatic s_reset;
    chk("reset pins", 32'({SCK_OE, SO_OE}), 32'h0);
    rc("ctrl", 4'h0, 9'h001);
    rc("flag", 4'h1, 9'h000);
    wr(4'h4, 4'hf);
    rc("unmapped", 4'h4, 9'h000);
    wr(4'h3, 4'h3);
    bus(1'b0, 4'h3, 4'h0);
    rc("port", 4'h3, 9'h007);
    chk("drive", 32'({SCK_OE, SCK_OUT}), 32'h3);
    wr(4'h3, 4'h0);
  endtask
  task automatic s_int(input logic [1:0] pm, input logic [2:0] cs,
      input logic [7:0] tx, pb);
    int n = 0;
    int h = (cs == 3'h6) ? 1 : 2 << (2 * (5 - cs));
    setup(pm, {1'b1, cs});
    wr(4'h6, tx[3:0]);
    wr(4'h7, tx[7:4]);
    cssp_peer_inst.load(pb);
    falls = 0;
    wr(4'h0, 4'h1);
    do bus(1'b0, 4'h1, 4'h0); while (d[0] !== 1'b1 && ++n < 20000);
    if (n >= 20000) stop();
    chk("pulses", 32'(falls), 32'h8);
    chk("period", 32'(per), 32'(2 * h));
    rc("done", 4'h0, 9'h001);
    rc("flag held", 4'h1, 9'h001);
    chk("so oe", 32'(SO_OE), 32'(pm[0]));
    if (cs != 3'h6) begin
      rd8();
      chk("rx", 32'({d[3:0], lo}), 32'(pm[1] ? pb : 8'h00));
      if (pm[0]) chk("tx", 32'(cssp_peer_inst.rx), 32'(tx));
    end
  endtask
  task automatic s_abort;
    int n = 0;
    setup(2'h3, 4'hb);
    wr(4'h0, 4'h1);
    do bus(1'b0, 4'h0, 4'h0); while (d[2] !== 1'b1 && ++n < 100);
    if (n >= 100) stop();
    wr(4'h5, 4'hb);
    rc("abort", 4'h0, 9'h101);
    rc("abort flag", 4'h1, 9'h001);
    chk("idle sck", 32'(SCK_OUT), 32'h1);
  endtask
  task automatic s_ext;
    setup(2'h3, 4'hf);
    wr(4'h6, 4'h4);
    wr(4'h7, 4'hc);
    cssp_peer_inst.load(8'h69);
    wr(4'h0, 4'h1);
    cssp_peer_inst.pulses(1, 4);
    rc("first", 4'h0, 9'h014);
    cssp_peer_inst.pulses(7, 4);
    rc("wrap", 4'h0, 9'h002);
    rc("wrap flag", 4'h1, 9'h001);
    rd8();
    chk("ext rx", 32'({d[3:0], lo}), 32'h69);
    chk("ext tx", 32'(cssp_peer_inst.rx), 32'hc4);
    wr(4'h1, 4'h1);
    cssp_peer_inst.pulses(3, 4);
    rc("extra", 4'h0, 9'h034);
    wr(4'h0, 4'h1);
    rc("restart", 4'h0, 9'h002);
    rc("restart flag", 4'h1, 9'h001);
  endtask
  task automatic s_pm;
    int n = 0;
    setup(2'h3, 4'hf);
    wr(4'h0, 4'h1);
    wr(4'h2, 4'h1);
    rc("pm change", 4'h0, 9'h001);
    cssp_peer_inst.pulses(2, 4);
    rc("ignored", 4'h0, 9'h001);
    wr(4'h5, 4'hf);
    setup(2'h0, 4'hd);
    wr(4'h0, 4'h1);
    falls = 0;
    do bus(1'b0, 4'h0, 4'h0); while (falls < 12 && ++n < 100);
    if (n >= 100) stop();
    chk("cont", 32'(d[8:0]), 32'h002);
    rc("cont flag", 4'h1, 9'h000);
  endtask
  initial begin
    {RSTN, READ, WRITE} = 3'h0;
    {ADDRESS, WRITEDATA, BYTEENABLE} = 42'h0;
    repeat (5) @(posedge MCLK);
    RSTN <= 1'b1;
    @(posedge MCLK);
    s_reset();
    s_int(2'h3, 3'h5, 8'ha5, 8'h3c);
    s_int(2'h1, 3'h4, 8'h96, 8'hff);
    s_int(2'h2, 3'h3, 8'h0f, 8'hc3);
    for (int c = 0; c < 3; c++) s_int(2'h3, 3'(c), 8'h5a, 8'h81);
    s_int(2'h3, 3'h6, 8'h00, 8'h00);
    s_abort();
    s_ext();
    s_pm();
    print_verdict();
  end
endmodule // tb_top
